// *** gpx_master_model.sv ***
`timescale 1ns/10ps
// ============================================================
// Command-byte master that stands in for the serial side.
// ============================================================
module gpx_master_model (
   input  wire logic               clk,
   output gpx_pkg::gpx_byte_t      cmd_byte,
   output logic                    wr_en,
   output gpx_pkg::gpx_byte_t      wr_data,
   output logic                    rd_en,
   input  wire gpx_pkg::gpx_byte_t rd_data,
   input  wire logic               rd_valid
);
   import gpx_pkg::*;

   // Idle bus at time zero, strobes low.
   initial begin
      cmd_byte = 8'h00;
      wr_data  = 8'h00;
      wr_en    = 1'b0;
      rd_en    = 1'b0;
   end

   // One write strobe per byte; released fields show the inverse so stale values never look valid.
   task automatic write_reg(input gpx_byte_t cmd, input gpx_byte_t data);
      @(posedge clk);
      cmd_byte <= cmd;
      wr_data  <= data;
      wr_en    <= 1'b1;
      @(posedge clk);
      wr_en    <= 1'b0;
      cmd_byte <= ~cmd;
      wr_data  <= ~data;
   endtask : write_reg

   // One read strobe; the answer is taken in the cycle in which it stands.
   task automatic read_reg(input gpx_byte_t cmd, output gpx_byte_t data, output bit seen);
      int n;
      @(posedge clk);
      cmd_byte <= cmd;
      rd_en    <= 1'b1;
      @(posedge clk);
      rd_en    <= 1'b0;
      cmd_byte <= ~cmd;
      #1;
      n = 0;
      while (rd_valid !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      seen = (rd_valid === 1'b1);
      data = rd_data;
   endtask : read_reg

   // Write strobe, then a read strobe at the very next edge, as back-to-back traffic allows.
   task automatic write_read(input gpx_byte_t cw, input gpx_byte_t d, input gpx_byte_t cr,
                             output gpx_byte_t data, output bit seen);
      @(posedge clk);
      cmd_byte <= cw;
      wr_data  <= d;
      wr_en    <= 1'b1;
      @(posedge clk);
      wr_en    <= 1'b0;
      wr_data  <= ~d;
      cmd_byte <= cr;
      rd_en    <= 1'b1;
      @(posedge clk);
      rd_en    <= 1'b0;
      cmd_byte <= ~cr;
      #1;
      seen = (rd_valid === 1'b1);
      data = rd_data;
   endtask : write_read
endmodule : gpx_master_model

// *** gpx_pkg.sv ***
// ============================================================
// Shared constants and types of the expander register block.
// ============================================================
package gpx_pkg;

   typedef logic [7:0] gpx_byte_t;

   // ============================================================
   // Command byte values that select each register.
   // ============================================================
   localparam gpx_byte_t CMD_PORT0     = 8'h00;
   localparam gpx_byte_t CMD_PORT1     = 8'h01;
   localparam gpx_byte_t CMD_LATCH0    = 8'h02;
   localparam gpx_byte_t CMD_LATCH1    = 8'h03;
   localparam gpx_byte_t CMD_INVERT0   = 8'h04;
   localparam gpx_byte_t CMD_INVERT1   = 8'h05;
   localparam gpx_byte_t CMD_DIR0      = 8'h06;
   localparam gpx_byte_t CMD_DIR1      = 8'h07;
   localparam gpx_byte_t CMD_CAPTURE0  = 8'h08;
   localparam gpx_byte_t CMD_CAPTURE1  = 8'h09;
   localparam gpx_byte_t CMD_CONTROL   = 8'h0A;
   localparam gpx_byte_t CMD_CTRL_ALIAS = 8'h0B;

   // ============================================================
   // Values after reset and field positions.
   // ============================================================
   localparam gpx_byte_t RST_PORT      = 8'h00;
   localparam gpx_byte_t RST_LATCH     = 8'h00;
   localparam gpx_byte_t RST_INVERT    = 8'h00;
   localparam gpx_byte_t RST_DIR       = 8'hFF;
   localparam gpx_byte_t RST_RDATA     = 8'h00;
   localparam gpx_byte_t UNMAPPED_READ = 8'h00;
   localparam logic      RST_RES_SEL   = 1'b0;
   localparam int        CTRL_RES_BIT  = 0;

   // ============================================================
   // Change detection times and the cycle counts derived from them.
   // ============================================================
   localparam int unsigned CLK_PERIOD_PS     = 5000;
   localparam int unsigned SLOW_DETECT_US    = 32000;
   localparam int unsigned FAST_DETECT_US    = 200;
   // Longest times, so the counts round down; worked in nanoseconds so the product fits in 32 bits.
   localparam int unsigned SLOW_DETECT_CYC   = (SLOW_DETECT_US * 1000) / (CLK_PERIOD_PS / 1000);
   localparam int unsigned FAST_DETECT_CYC   = (FAST_DETECT_US * 1000) / (CLK_PERIOD_PS / 1000);

   // One-hot states of each port's change capture.
   typedef enum logic [1:0] {
      CAP_IDLE = 2'b01,
      CAP_HELD = 2'b10
   } gpx_cap_state_t;

endpackage : gpx_pkg

// *** gpx_regblock.sv ***
`timescale 1ns/10ps
// ============================================================
// Register block of a two-port 16-bit I/O expander.
// ============================================================
module gpx_regblock #(
   parameter int unsigned SLOW_CYC = gpx_pkg::SLOW_DETECT_CYC,
   parameter int unsigned FAST_CYC = gpx_pkg::FAST_DETECT_CYC
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire gpx_pkg::gpx_byte_t cmd_byte,
   input  wire logic             wr_en,
   input  wire gpx_pkg::gpx_byte_t wr_data,
   input  wire logic             rd_en,
   output gpx_pkg::gpx_byte_t    rd_data,
   output logic                  rd_valid,
   input  wire gpx_pkg::gpx_byte_t port_zero_pins_level,
   input  wire gpx_pkg::gpx_byte_t port_one_pins_level,
   output gpx_pkg::gpx_byte_t    port_zero_pins_drive,
   output gpx_pkg::gpx_byte_t    port_one_pins_drive,
   output gpx_pkg::gpx_byte_t    port_zero_pins_enable,
   output gpx_pkg::gpx_byte_t    port_one_pins_enable,
   output logic                  sample_resolution_sel
);
   import gpx_pkg::*;

   // ============================================================
   // Storage.
   // ============================================================
   gpx_byte_t      latch_ff   [2];
   gpx_byte_t      invert_ff  [2];
   gpx_byte_t      dir_ff     [2];
   gpx_byte_t      capture_ff [2];
   gpx_byte_t      ref_ff     [2];
   gpx_cap_state_t cap_st_ff  [2];
   gpx_byte_t      drive_ff   [2];
   gpx_byte_t      enable_ff  [2];
   gpx_byte_t      pins       [2];
   gpx_byte_t      nxt_latch  [2];
   gpx_byte_t      nxt_dir    [2];
   logic           res_sel_ff;
   logic           nxt_res_sel;
   gpx_byte_t      rd_data_ff;
   logic           rd_valid_ff;
   gpx_byte_t      nxt_rd_data;

   gpx_tick_if tk ();

   // ============================================================
   // Command decode.
   // ============================================================
   // True when the command selects the given register of port p.
   function automatic logic cmd_is(input gpx_byte_t cmd, input gpx_byte_t base, input int p);
      cmd_is = (cmd == (base + gpx_byte_t'(p)));
   endfunction : cmd_is

   // Both control addresses reach the single control bit.
   function automatic logic cmd_is_ctrl(input gpx_byte_t cmd);
      cmd_is_ctrl = (cmd == CMD_CONTROL) || (cmd == CMD_CTRL_ALIAS);
   endfunction : cmd_is_ctrl

   // Pin levels gathered by port index; bit n is pin n.
   assign pins[0] = port_zero_pins_level;
   assign pins[1] = port_one_pins_level;

   // ============================================================
   // Per-port latch, masks, drivers and change capture.
   // ============================================================
   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_port
         logic wr_port;
         logic wr_latch;
         logic wr_inv;
         logic wr_dir;
         logic rd_clear;
         logic differs;

         // Port and latch writes both land in the same latch.
         assign wr_port  = wr_en && cmd_is(cmd_byte, CMD_PORT0, p);
         assign wr_latch = wr_en && cmd_is(cmd_byte, CMD_LATCH0, p);
         assign wr_inv   = wr_en && cmd_is(cmd_byte, CMD_INVERT0, p);
         assign wr_dir   = wr_en && cmd_is(cmd_byte, CMD_DIR0, p);
         assign rd_clear = rd_en && (cmd_is(cmd_byte, CMD_PORT0, p) || cmd_is(cmd_byte, CMD_CAPTURE0, p));

         // Only input pins count as a change against the pin levels taken at the last port or capture read.
         assign differs = |((pins[p] ^ ref_ff[p]) & dir_ff[p]);

         // Next latch and direction values, so the pin flops follow in step.
         assign nxt_latch[p] = (wr_port || wr_latch) ? wr_data : latch_ff[p];
         assign nxt_dir[p]   = wr_dir ? wr_data : dir_ff[p];

         // Latch and masks with their reset values.
         always_ff @(posedge clk) begin
            if (rst) begin
               latch_ff[p]  <= RST_LATCH;
               invert_ff[p] <= RST_INVERT;
               dir_ff[p]    <= RST_DIR;
            end else begin
               latch_ff[p] <= nxt_latch[p];
               dir_ff[p]   <= nxt_dir[p];
               if (wr_inv) begin
                  invert_ff[p] <= wr_data;
               end
            end
         end

         // Pin drive and enable come straight from flops; inputs never drive.
         always_ff @(posedge clk) begin
            if (rst) begin
               drive_ff[p]  <= RST_LATCH;
               enable_ff[p] <= ~RST_DIR;
            end else begin
               drive_ff[p]  <= nxt_latch[p];
               enable_ff[p] <= ~nxt_dir[p];
            end
         end

         // Capture state: the first change captures; later ones do not until a read clears it or a tick sees no change.
         always_ff @(posedge clk) begin
            if (rst) begin
               cap_st_ff[p] <= CAP_IDLE;
               ref_ff[p]    <= RST_PORT;
            end else begin
               if (rd_clear) begin
                  ref_ff[p] <= pins[p];
               end
               case (cap_st_ff[p])
                  CAP_IDLE: begin
                     // A new change wins over a read in the same cycle.
                     if (tk.tick && differs) begin
                        cap_st_ff[p] <= CAP_HELD;
                     end
                  end
                  CAP_HELD: begin
                     if (rd_clear || (tk.tick && !differs)) begin
                        cap_st_ff[p] <= CAP_IDLE;
                     end
                  end
                  default: begin
                     cap_st_ff[p] <= CAP_IDLE;
                  end
               endcase
            end
         end

         // Captured value has no reset; software writes never reach it.
         always_ff @(posedge clk) begin
            if ((cap_st_ff[p] == CAP_IDLE) && tk.tick && differs) begin
               capture_ff[p] <= pins[p];
            end
         end
      end
   endgenerate

   // ============================================================
   // Control register and sample divider.
   // ============================================================
   assign nxt_res_sel = (wr_en && cmd_is_ctrl(cmd_byte)) ? wr_data[CTRL_RES_BIT] : res_sel_ff;

   // Only the resolution bit is stored; the other seven bits are not kept.
   always_ff @(posedge clk) begin
      if (rst) begin
         res_sel_ff <= RST_RES_SEL;
      end else begin
         res_sel_ff <= nxt_res_sel;
      end
   end

   assign tk.fast_sel = res_sel_ff;

   gpx_sample_div #(
      .SLOW_CYC (SLOW_CYC),
      .FAST_CYC (FAST_CYC)
   ) u_div (
      .clk (clk),
      .rst (rst),
      .tk  (tk)
   );

   // ============================================================
   // Read path.
   // ============================================================
   // Read mux; pins are sampled at the request edge, so the answer is one cycle old.
   always_comb begin
      nxt_rd_data = UNMAPPED_READ;
      case (cmd_byte)
         CMD_PORT0:      nxt_rd_data = pins[0] ^ invert_ff[0];
         CMD_PORT1:      nxt_rd_data = pins[1] ^ invert_ff[1];
         CMD_LATCH0:     nxt_rd_data = latch_ff[0];
         CMD_LATCH1:     nxt_rd_data = latch_ff[1];
         CMD_INVERT0:    nxt_rd_data = invert_ff[0];
         CMD_INVERT1:    nxt_rd_data = invert_ff[1];
         CMD_DIR0:       nxt_rd_data = dir_ff[0];
         CMD_DIR1:       nxt_rd_data = dir_ff[1];
         CMD_CAPTURE0:   nxt_rd_data = capture_ff[0];
         CMD_CAPTURE1:   nxt_rd_data = capture_ff[1];
         CMD_CONTROL,
         CMD_CTRL_ALIAS: nxt_rd_data = {7'h00, res_sel_ff};
         default:        nxt_rd_data = UNMAPPED_READ;
      endcase
   end

   // Read answer register and its one-cycle valid pulse.
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data_ff  <= RST_RDATA;
         rd_valid_ff <= 1'b0;
      end else begin
         rd_valid_ff <= rd_en;
         if (rd_en) begin
            rd_data_ff <= nxt_rd_data;
         end
      end
   end

   // ============================================================
   // Outputs.
   // ============================================================
   assign rd_data               = rd_data_ff;
   assign rd_valid              = rd_valid_ff;
   assign port_zero_pins_drive  = drive_ff[0];
   assign port_one_pins_drive   = drive_ff[1];
   assign port_zero_pins_enable = enable_ff[0];
   assign port_one_pins_enable  = enable_ff[1];
   assign sample_resolution_sel = res_sel_ff;

   // ============================================================
   // Assertions.
   // ============================================================
   sequence s_wr(gpx_byte_t c);
      wr_en && !rd_en && (cmd_byte == c);
   endsequence

   sequence s_rd(gpx_byte_t c);
      rd_en && !wr_en && (cmd_byte == c);
   endsequence

   property p_port_write;
      @(posedge clk) disable iff (rst)
         s_wr(CMD_PORT0) |=> (port_zero_pins_drive == $past(wr_data)) && (latch_ff[0] == $past(wr_data));
   endproperty
   a_port_write: assert property (p_port_write) else $error("port write did not reach latch and pins");

   property p_port_read;
      @(posedge clk) disable iff (rst)
         s_rd(CMD_PORT1) |=> rd_valid && (rd_data == ($past(port_one_pins_level) ^ $past(invert_ff[1])));
   endproperty
   a_port_read: assert property (p_port_read) else $error("port read did not return inverted pin levels");

   property p_invert_read;
      @(posedge clk) disable iff (rst)
         s_wr(CMD_INVERT0) ##1 s_rd(CMD_PORT0) |=> (rd_data == ($past(port_zero_pins_level) ^ $past(wr_data, 2)));
   endproperty
   a_invert_read: assert property (p_invert_read) else $error("invert mask not applied to port read");

   property p_latch_read;
      @(posedge clk) disable iff (rst)
         s_wr(CMD_LATCH1) ##1 s_rd(CMD_LATCH1) |=> rd_valid && (rd_data == $past(wr_data, 2));
   endproperty
   a_latch_read: assert property (p_latch_read) else $error("latch read did not return written value");

   property p_latch_drive;
      @(posedge clk) disable iff (rst)
         s_wr(CMD_LATCH1) |=> (port_one_pins_drive == $past(wr_data));
   endproperty
   a_latch_drive: assert property (p_latch_drive) else $error("latch write did not update pin drive");

   property p_dir_enable;
      @(posedge clk) disable iff (rst)
         s_wr(CMD_DIR0) |=> (port_zero_pins_enable == ~$past(wr_data)) && (dir_ff[0] == $past(wr_data));
   endproperty
   a_dir_enable: assert property (p_dir_enable) else $error("direction write did not set drive enables");

   property p_input_no_drive;
      @(posedge clk) disable iff (rst)
         ((port_one_pins_enable & dir_ff[1]) == 8'h00);
   endproperty
   a_input_no_drive: assert property (p_input_no_drive) else $error("input pin has its driver enabled");

   property p_reset_values;
      @(posedge clk)
         rst |=> (dir_ff[0] == RST_DIR) && (dir_ff[1] == RST_DIR) && (latch_ff[0] == RST_LATCH)
                 && (invert_ff[1] == RST_INVERT) && (port_zero_pins_enable == 8'h00) && !sample_resolution_sel;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

   property p_ctrl_alias;
      @(posedge clk) disable iff (rst)
         s_wr(CMD_CTRL_ALIAS) ##1 s_rd(CMD_CONTROL) |=> (rd_data == {7'h00, $past(wr_data[0], 2)});
   endproperty
   a_ctrl_alias: assert property (p_ctrl_alias) else $error("control alias does not share storage");

   property p_ctrl_upper_zero;
      @(posedge clk) disable iff (rst)
         s_rd(CMD_CONTROL) |=> (rd_data[7:1] == 7'h00);
   endproperty
   a_ctrl_upper_zero: assert property (p_ctrl_upper_zero) else $error("unimplemented control bits not zero");

   property p_capture_ro;
      @(posedge clk) disable iff (rst)
         s_wr(CMD_CAPTURE0) ##0 !tk.tick |=> $stable(capture_ff[0]);
   endproperty
   a_capture_ro: assert property (p_capture_ro) else $error("capture register changed on write");

endmodule : gpx_regblock

// *** gpx_regblock_test.sv ***
`timescale 1ns/10ps
// ============================================================
// Self-checking bench of the expander register block.
// ============================================================
module gpx_regblock_test;
   import gpx_pkg::*;

   // Short sampling counts keep the change-capture wait brief.
   localparam int unsigned SLOW_SIM    = 16;
   localparam int unsigned FAST_SIM    = 4;
   localparam int          WATCHDOG_NS = 100000;

   logic      clk;
   logic      rst;
   gpx_byte_t cmd_byte;
   gpx_byte_t wr_data;
   gpx_byte_t rd_data;
   logic      wr_en;
   logic      rd_en;
   logic      rd_valid;
   gpx_byte_t pin_lvl0;
   gpx_byte_t pin_lvl1;
   gpx_byte_t drv0;
   gpx_byte_t drv1;
   gpx_byte_t oen0;
   gpx_byte_t oen1;
   logic      res_sel;
   gpx_byte_t ext[2];
   gpx_byte_t m_lat[2];
   gpx_byte_t m_inv[2];
   gpx_byte_t m_dir[2];
   logic      m_ctl;
   int        n_fail;
   int        tests_run;
   integer    seed;

   // Pin wire: the block wins where it drives, the outside world elsewhere.
   assign pin_lvl0 = (drv0 & oen0) | (ext[0] & ~oen0);
   assign pin_lvl1 = (drv1 & oen1) | (ext[1] & ~oen1);

   always #2.5 clk = ~clk;

   gpx_regblock #(.SLOW_CYC(SLOW_SIM), .FAST_CYC(FAST_SIM)) i_gpx_regblock (
      .clk                   (clk),
      .rst                   (rst),
      .cmd_byte              (cmd_byte),
      .wr_en                 (wr_en),
      .wr_data               (wr_data),
      .rd_en                 (rd_en),
      .rd_data               (rd_data),
      .rd_valid              (rd_valid),
      .port_zero_pins_level  (pin_lvl0),
      .port_one_pins_level   (pin_lvl1),
      .port_zero_pins_drive  (drv0),
      .port_one_pins_drive   (drv1),
      .port_zero_pins_enable (oen0),
      .port_one_pins_enable  (oen1),
      .sample_resolution_sel (res_sel)
   );

   gpx_master_model i_gpx_master_model (
      .clk      (clk),
      .cmd_byte (cmd_byte),
      .wr_en    (wr_en),
      .wr_data  (wr_data),
      .rd_en    (rd_en),
      .rd_data  (rd_data),
      .rd_valid (rd_valid)
   );

   // ============================================================
   // Comparison, verdict and reference model.
   // ============================================================
   task automatic check(input gpx_byte_t seen, input gpx_byte_t exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test();
      $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   // Expected read value; an output pin shows its latch, an input pin the outside level.
   function automatic gpx_byte_t exp_rd(input gpx_byte_t c);
      case (c)
         8'h00, 8'h01: exp_rd = ((m_lat[c[0]] & ~m_dir[c[0]]) | (ext[c[0]] & m_dir[c[0]])) ^ m_inv[c[0]];
         8'h02, 8'h03: exp_rd = m_lat[c[0]];
         8'h04, 8'h05: exp_rd = m_inv[c[0]];
         8'h06, 8'h07: exp_rd = m_dir[c[0]];
         8'h0A, 8'h0B: exp_rd = {7'h00, m_ctl};
         default:      exp_rd = 8'h00;
      endcase
   endfunction : exp_rd

   // Model side of a write; capture and unmapped commands leave the model untouched.
   task automatic model_write(input gpx_byte_t c, input gpx_byte_t d);
      case (c)
         8'h00, 8'h01, 8'h02, 8'h03: m_lat[c[0]] = d;
         8'h04, 8'h05: m_inv[c[0]] = d;
         8'h06, 8'h07: m_dir[c[0]] = d;
         8'h0A, 8'h0B: m_ctl = d[0];
         default: ;
      endcase
   endtask : model_write

   // Model values after reset.
   task automatic model_reset();
      m_lat = '{8'h00, 8'h00};
      m_inv = '{8'h00, 8'h00};
      m_dir = '{8'hFF, 8'hFF};
      m_ctl = 1'b0;
   endtask : model_reset

   // Write through the master, then compare pin drive, enable and sample select with the model.
   task automatic do_write(input gpx_byte_t c, input gpx_byte_t d);
      model_write(c, d);
      i_gpx_master_model.write_reg(c, d);
      #1;
      check(drv0, m_lat[0]);
      check(drv1, m_lat[1]);
      check(oen0, ~m_dir[0]);
      check(oen1, ~m_dir[1]);
      check({7'h00, res_sel}, {7'h00, m_ctl});
   endtask : do_write

   task automatic read_expect(input gpx_byte_t c, input gpx_byte_t e);
      gpx_byte_t d;
      bit        seen;
      i_gpx_master_model.read_reg(c, d, seen);
      check({7'h00, seen}, 8'h01);
      check(d, e);
   endtask : read_expect

   // A read right behind a write must already see what the write stored.
   task automatic wr_rd_expect(input gpx_byte_t cw, input gpx_byte_t d, input gpx_byte_t cr);
      gpx_byte_t q;
      bit        seen;
      model_write(cw, d);
      i_gpx_master_model.write_read(cw, d, cr, q, seen);
      check({7'h00, seen}, 8'h01);
      check(q, exp_rd(cr));
   endtask : wr_rd_expect

   // Every register with a defined value, read and compared; capture registers are left out.
   task automatic read_all();
      for (int i = 0; i < 12; i++) begin
         if (i != 8 && i != 9) begin
            read_expect(8'(i), exp_rd(8'(i)));
         end
      end
   endtask : read_all

   // ============================================================
   // Main sequence.
   // ============================================================
   initial begin
      gpx_byte_t c;
      gpx_byte_t r;
      clk       = 1'b0;
      rst       = 1'b1;
      ext[0]    = 8'h00;
      ext[1]    = 8'h00;
      model_reset();
      n_fail    = 0;
      tests_run = 0;
      seed      = 32'hd7ccb2f4;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      check(drv0, 8'h00);
      check(oen0 | oen1, 8'h00);
      check({7'h00, res_sel}, 8'h00);
      read_all();
      // A held capture must survive a write aimed at it.
      @(posedge clk);
      ext[0] <= 8'h5A;
      repeat (4 * SLOW_SIM) @(posedge clk);
      do_write(CMD_CAPTURE0, 8'hC3);
      read_expect(CMD_CAPTURE0, 8'h5A);
      do_write(CMD_CTRL_ALIAS, 8'hFF);
      read_expect(CMD_CONTROL, exp_rd(CMD_CONTROL));
      do_write(CMD_PORT1, 8'h3C);
      read_expect(CMD_LATCH1, 8'h3C);
      // Back-to-back write and read pairs.
      wr_rd_expect(CMD_INVERT0, 8'hA5, CMD_PORT0);
      wr_rd_expect(CMD_LATCH1, 8'h96, CMD_LATCH1);
      wr_rd_expect(CMD_CTRL_ALIAS, 8'hFE, CMD_CONTROL);
      // Random traffic over mapped, read-only and unmapped commands.
      for (int i = 0; i < 250; i++) begin
         @(posedge clk);
         ext[0] <= 8'($random(seed));
         ext[1] <= 8'($random(seed));
         c = 8'($random(seed)) & 8'h1F;
         do_write(c, 8'($random(seed)));
         r = 8'($random(seed)) & 8'h1F;
         if (r != 8'h08 && r != 8'h09) begin
            read_expect(r, exp_rd(r));
         end
      end
      // A reset in mid-run must bring every register except the capture registers back to its value after reset.
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      model_reset();
      @(posedge clk);
      #1;
      check(drv0 | drv1, 8'h00);
      check(oen0 | oen1, 8'h00);
      check({7'h00, res_sel}, 8'h00);
      read_all();
      finish_test();
   end

   // Watchdog against a hung handshake.
   initial begin
      #(WATCHDOG_NS);
      n_fail++;
      finish_test();
   end
endmodule : gpx_regblock_test

// *** gpx_sample_div.sv ***
`timescale 1ns/10ps
// ============================================================
// Divider that paces port sampling for change detection.
// ============================================================
module gpx_sample_div #(
   parameter int unsigned SLOW_CYC = gpx_pkg::SLOW_DETECT_CYC,
   parameter int unsigned FAST_CYC = gpx_pkg::FAST_DETECT_CYC
) (
   input  wire logic clk,
   input  wire logic rst,
   gpx_tick_if.divider tk
);
   import gpx_pkg::*;

   logic [31:0] cnt_ff;
   logic        tick_ff;
   logic [31:0] limit;

   // The fast rate costs more activity; the slow one is the default.
   assign limit = tk.fast_sel ? 32'(FAST_CYC - 1) : 32'(SLOW_CYC - 1);
   assign tk.tick = tick_ff;

   // Free-running count; it wraps at or beyond the limit so a rate change cannot stall it.
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff  <= 32'h00000000;
         tick_ff <= 1'b0;
      end else if (cnt_ff >= limit) begin
         cnt_ff  <= 32'h00000000;
         tick_ff <= 1'b1;
      end else begin
         cnt_ff  <= cnt_ff + 32'h00000001;
         tick_ff <= 1'b0;
      end
   end

endmodule : gpx_sample_div

// *** gpx_tick_if.sv ***
`timescale 1ns/10ps
// ============================================================
// Sampling rate select and sample tick between top and divider.
// ============================================================
interface gpx_tick_if;
   logic fast_sel;
   logic tick;
   modport ctrl (output fast_sel, input tick);
   modport divider (input fast_sel, output tick);
endinterface : gpx_tick_if
